// file: rtl/tcoc_timer.v
// What this block does
// - Width bit picks 16-bit or 8-bit count
// - Clock source bit selects input pin edges
// - Trigger 000: software start only
// - Trigger 001: valid edge starts and captures
// - Trigger 010: both edges start and capture
// - Trigger 100: master interrupt starts slave
// - Edge field picks fall, rise, both
// - Modes 0000/0001 interval; 0001 irq at start
// - Modes 0100/0101 capture; 0101 irq at start
// - Mode 0110 event counter, no start irq
// - One-count; 1000 ignores, 1001 honours retrigger
// - Mode 1100 capture one-count, next trigger captures and stops
// - Master output toggles on own interrupt
// - Slave output set by master, reset own
// - Polarity bit 0 high, 1 low active
// - Output value bit holds pin level before polarity
// - Disabled output: software writes drive pin
// - Enabled output: writes ignored, timer drives
// - Enabled pin gives square wave or PWM
// - Clock field picks prescaler 0, 2, 1, 3
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`include "tcoc_defs.vh"

module tcoc_timer #(
    parameter CNT_W = 16
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Prescaler clock enables, one-cycle pulses
    input wire [3:0] prescale_tick,
    // Timer input pin of channel 3
    input wire timer_input_pin,
    // Interrupts of the other channels (0 is master)
    input wire master_timer_irq,
    input wire ch1_timer_irq,
    input wire ch2_timer_irq,
    // Channel 3 interrupt and output pins of channels 3..1
    output reg channel_timer_irq,
    output wire [3:1] timer_out_pin
);

    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;
    // Unit step at counter width
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    reg [15:0] channel3_mode_config;
    reg [3:1] output_mode_select;
    reg [3:1] output_polarity_select;
    reg [3:1] output_pin_value;
    reg [3:1] output_pin_enable;
    reg [CNT_W-1:0] data_reg;
    reg [CNT_W-1:0] count;
    reg [1:0] state;
    reg sw_start;
    reg sw_stop;
    reg pin_meta;
    reg pin_sync;
    reg pin_prev;
    reg first_edge;

    wire [1:0] prescaler_clock_select;
    wire count_clock_source;
    wire width_select;
    wire [2:0] trigger_select;
    wire [1:0] input_edge_select;
    wire [3:0] operating_mode;
    wire wr_en;
    wire rd_setup;
    wire mapped;
    wire pin_rise;
    wire pin_fall;
    wire valid_edge;
    wire count_tick;
    wire start_trig;
    wire running;
    wire [CNT_W-1:0] width_mask;
    wire [CNT_W-1:0] count_m;
    wire [CNT_W-1:0] data_m;
    wire at_zero;
    wire [3:1] own_irq;
    wire is_capture;
    wire is_one;
    wire irq_at_start;

    assign prescaler_clock_select = channel3_mode_config[`TCOC_CKS_HI:`TCOC_CKS_LO];
    assign count_clock_source = channel3_mode_config[`TCOC_CCS_BIT];
    assign width_select = channel3_mode_config[`TCOC_SPLIT_BIT];
    assign trigger_select = channel3_mode_config[`TCOC_STS_HI:`TCOC_STS_LO];
    assign input_edge_select = channel3_mode_config[`TCOC_CIS_HI:`TCOC_CIS_LO];
    assign operating_mode = channel3_mode_config[`TCOC_MD_HI:`TCOC_MD_LO];

    // Prescaler index from clock-select code
    function [1:0] cks_index;
        input [1:0] code;
        begin
            case (code)
                2'h0: cks_index = 2'h0;
                2'h1: cks_index = 2'h2;
                2'h2: cks_index = 2'h1;
                default: cks_index = 2'h3;
            endcase
        end
    endfunction

    // Write strobe for one register offset
    function wr_hit;
        input en;
        input [7:0] addr;
        input [7:0] offset;
        begin
            wr_hit = en && (addr == offset);
        end
    endfunction

    // APB decode
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == `TCOC_OFF_MODE) || (paddr == `TCOC_OFF_TOM)
        || (paddr == `TCOC_OFF_TOL) || (paddr == `TCOC_OFF_TO)
        || (paddr == `TCOC_OFF_TOE) || (paddr == `TCOC_OFF_DATA)
        || (paddr == `TCOC_OFF_CNT) || (paddr == `TCOC_OFF_CTRL);
    assign pslverr = psel && penable && !mapped;

    // Read data latched in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
        begin
            case (paddr)
                `TCOC_OFF_MODE: prdata <= {16'h0000, channel3_mode_config};
                `TCOC_OFF_TOM: prdata <= {28'h0000000, output_mode_select, 1'b0};
                `TCOC_OFF_TOL: prdata <= {28'h0000000, output_polarity_select, 1'b0};
                `TCOC_OFF_TO: prdata <= {28'h0000000, output_pin_value, 1'b0};
                `TCOC_OFF_TOE: prdata <= {28'h0000000, output_pin_enable, 1'b0};
                `TCOC_OFF_DATA: prdata <= {{(32-CNT_W){1'b0}}, data_reg};
                `TCOC_OFF_CNT: prdata <= {{(32-CNT_W){1'b0}}, count};
                `TCOC_OFF_CTRL: prdata <= {31'h00000000, running};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Configuration registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel3_mode_config <= `TCOC_RST_MODE;
            output_mode_select <= `TCOC_RST_OUT;
            output_polarity_select <= `TCOC_RST_OUT;
            output_pin_enable <= `TCOC_RST_OUT;
            sw_start <= 1'b0;
            sw_stop <= 1'b0;
        end
        else
        begin
            sw_start <= wr_hit(wr_en, paddr, `TCOC_OFF_CTRL) && pwdata[`TCOC_CTRL_START];
            sw_stop <= wr_hit(wr_en, paddr, `TCOC_OFF_CTRL) && pwdata[`TCOC_CTRL_STOP];
            if (wr_hit(wr_en, paddr, `TCOC_OFF_MODE))
                channel3_mode_config <= pwdata[15:0] & `TCOC_MODE_MASK;
            if (wr_hit(wr_en, paddr, `TCOC_OFF_TOM))
                output_mode_select <= pwdata[`TCOC_OUT_HI:`TCOC_OUT_LO];
            if (wr_hit(wr_en, paddr, `TCOC_OFF_TOL))
                output_polarity_select <= pwdata[`TCOC_OUT_HI:`TCOC_OUT_LO];
            if (wr_hit(wr_en, paddr, `TCOC_OFF_TOE))
                output_pin_enable <= pwdata[`TCOC_OUT_HI:`TCOC_OUT_LO];
        end
    end

    // Input pin synchroniser and edge history
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= timer_input_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_rise = pin_sync && !pin_prev;
    assign pin_fall = !pin_sync && pin_prev;

    assign valid_edge = (input_edge_select == `TCOC_CIS_FALL) ? pin_fall :
        (input_edge_select == `TCOC_CIS_RISE) ? pin_rise : (pin_rise || pin_fall);

    assign count_tick = count_clock_source ? valid_edge
        : prescale_tick[cks_index(prescaler_clock_select)];

    assign start_trig = sw_start
        || ((trigger_select == `TCOC_STS_EDGE) && valid_edge)
        || ((trigger_select == `TCOC_STS_BOTH) && (pin_rise || pin_fall))
        || ((trigger_select == `TCOC_STS_MASTER) && master_timer_irq);

    assign width_mask = width_select ? {{(CNT_W-8){1'b0}}, 8'hff} : {CNT_W{1'b1}};
    assign count_m = count & width_mask;
    assign data_m = data_reg & width_mask;
    assign at_zero = (count_m == {CNT_W{1'b0}});
    assign running = (state == ST_RUN);

    assign is_capture = (operating_mode == `TCOC_MD_CAP)
        || (operating_mode == `TCOC_MD_CAP_IRQ) || (operating_mode == `TCOC_MD_CAP_ONE);
    assign is_one = (operating_mode == `TCOC_MD_ONE) || (operating_mode == `TCOC_MD_ONE_RE);
    assign irq_at_start = (operating_mode == `TCOC_MD_INT_IRQ)
        || (operating_mode == `TCOC_MD_CAP_IRQ);

    // Channel 3 counter
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            count <= {CNT_W{1'b0}};
            data_reg <= `TCOC_RST_DATA;
            channel_timer_irq <= 1'b0;
            first_edge <= 1'b0;
        end
        else
        begin
            channel_timer_irq <= 1'b0;
            if (wr_hit(wr_en, paddr, `TCOC_OFF_DATA))
                data_reg <= pwdata[CNT_W-1:0];
            case (state)
                ST_IDLE:
                begin
                    if (start_trig)
                    begin
                        state <= ST_RUN;
                        count <= is_capture ? {CNT_W{1'b0}} : data_m;
                        channel_timer_irq <= irq_at_start;
                        first_edge <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    first_edge <= 1'b0;
                    if (sw_stop)
                        state <= ST_IDLE;
                    else if (is_capture)
                    begin
                        // capture on trigger, skip the starting edge
                        if (start_trig && !first_edge)
                        begin
                            data_reg <= count_m;
                            count <= {CNT_W{1'b0}};
                            channel_timer_irq <= 1'b1;
                            if (operating_mode == `TCOC_MD_CAP_ONE)
                                state <= ST_IDLE;
                        end
                        else if (count_tick)
                            count <= (count_m + CNT_ONE) & width_mask;
                    end
                    else if (start_trig && (operating_mode == `TCOC_MD_ONE_RE))
                        count <= data_m;
                    else if (count_tick)
                    begin
                        if (at_zero)
                        begin
                            channel_timer_irq <= 1'b1;
                            count <= data_m;
                            if (is_one)
                                state <= ST_IDLE;
                        end
                        else
                            count <= (count_m - CNT_ONE) & width_mask;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign own_irq = {channel_timer_irq, ch2_timer_irq, ch1_timer_irq};

    // Output value bits of channels 3..1
    always @(posedge pclk or negedge presetn)
    begin : out_ctl
        integer n;
        if (!presetn)
            output_pin_value <= `TCOC_RST_OUT;
        else
        begin
            for (n = 1; n <= 3; n = n + 1)
            begin
                if (!output_pin_enable[n])
                begin
                    if (wr_hit(wr_en, paddr, `TCOC_OFF_TO))
                        output_pin_value[n] <= pwdata[n];
                end
                else if (!output_mode_select[n])
                begin
                    if (own_irq[n])
                        output_pin_value[n] <= !output_pin_value[n];
                end
                else
                begin
                    // set at period start, reset at pulse end
                    if (own_irq[n])
                        output_pin_value[n] <= 1'b0;
                    else if (master_timer_irq)
                        output_pin_value[n] <= 1'b1;
                end
            end
        end
    end

    // pin level with polarity in timer mode
    assign timer_out_pin = output_pin_value ^ (output_polarity_select & output_pin_enable);

endmodule

// file: rtl/tcoc_defs.vh
`ifndef TCOC_DEFS_VH
`define TCOC_DEFS_VH

// Register byte offsets
`define TCOC_OFF_MODE 8'h00
`define TCOC_OFF_TOM 8'h04
`define TCOC_OFF_TOL 8'h08
`define TCOC_OFF_TO 8'h0c
`define TCOC_OFF_TOE 8'h10
`define TCOC_OFF_DATA 8'h14
`define TCOC_OFF_CNT 8'h18
`define TCOC_OFF_CTRL 8'h1c

// Reset values
`define TCOC_RST_MODE 16'h0000
`define TCOC_RST_OUT 3'h0
`define TCOC_RST_DATA 16'h0000

// Mode register fields
`define TCOC_CKS_HI 15
`define TCOC_CKS_LO 14
`define TCOC_CCS_BIT 12
`define TCOC_SPLIT_BIT 11
`define TCOC_STS_HI 10
`define TCOC_STS_LO 8
`define TCOC_CIS_HI 7
`define TCOC_CIS_LO 6
`define TCOC_MD_HI 3
`define TCOC_MD_LO 0
`define TCOC_MODE_MASK 16'hdfcf

// Trigger select codes
`define TCOC_STS_SW 3'h0
`define TCOC_STS_EDGE 3'h1
`define TCOC_STS_BOTH 3'h2
`define TCOC_STS_MASTER 3'h4

// Input edge codes
`define TCOC_CIS_FALL 2'h0
`define TCOC_CIS_RISE 2'h1

// Operating mode codes
`define TCOC_MD_INT 4'h0
`define TCOC_MD_INT_IRQ 4'h1
`define TCOC_MD_CAP 4'h4
`define TCOC_MD_CAP_IRQ 4'h5
`define TCOC_MD_EVT 4'h6
`define TCOC_MD_ONE 4'h8
`define TCOC_MD_ONE_RE 4'h9
`define TCOC_MD_CAP_ONE 4'hc

// Control register bits
`define TCOC_CTRL_START 0
`define TCOC_CTRL_STOP 1

// Output register channel bits (channels 3..1)
`define TCOC_OUT_HI 3
`define TCOC_OUT_LO 1

`endif

// file: tb/tcoc_led_model.sv
`timescale 1ns/1ns
module tcoc_led_model (
    // Timer output pins
    input wire [3:1] drive_pin,
    // Lit state of each LED
    output wire [3:1] led_lit
);
    // Low pin level sinks the LED current
    assign led_lit = ~drive_pin;
endmodule

// file: tb/tcoc_timer_props.sv
`timescale 1ns/1ns
module tcoc_timer_props (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Timer side
    input wire [3:0] prescale_tick,
    input wire timer_input_pin,
    input wire master_timer_irq,
    input wire ch1_timer_irq,
    input wire ch2_timer_irq,
    input wire channel_timer_irq,
    input wire [3:1] timer_out_pin
);
    wire wr = psel && penable && pwrite;
    reg [3:0] md_sh;
    reg [3:1] slv_sh;
    reg [3:1] pol_sh;
    reg [3:1] en_sh;

    // Shadow of mode and output control
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {md_sh, slv_sh, pol_sh, en_sh} <= 13'h0000;
        else if (wr)
        begin
            if (paddr == 8'h00)
                md_sh <= pwdata[3:0];
            if (paddr == 8'h04)
                slv_sh <= pwdata[3:1];
            if (paddr == 8'h08)
                pol_sh <= pwdata[3:1];
            if (paddr == 8'h10)
                en_sh <= pwdata[3:1];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (
        psel && penable && !pwrite && paddr >= 8'h20 |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_ok: assert property (
        psel && penable && paddr < 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_master_toggle: assert property (
        ch1_timer_irq && en_sh[1] && !slv_sh[1] && !wr
        |=> timer_out_pin[1] != $past(timer_out_pin[1]))
        else $error("master output did not toggle");
    a_slave_set: assert property (
        master_timer_irq && !ch2_timer_irq && en_sh[2] && slv_sh[2] && !wr
        |=> timer_out_pin[2] == !pol_sh[2])
        else $error("slave output not set");
    a_slave_reset: assert property (
        ch2_timer_irq && en_sh[2] && slv_sh[2] && !wr |=> timer_out_pin[2] == pol_sh[2])
        else $error("slave output not reset");
    a_off_hold: assert property (
        !en_sh[3] && !wr |=> $stable(timer_out_pin[3]))
        else $error("disabled output moved");
    a_start_irq: assert property (
        wr && paddr == 8'h1c && pwdata[1:0] == 2'h1 && md_sh == 4'h1
        |-> ##[1:3] channel_timer_irq)
        else $error("no interrupt at start");

    c_toggle: cover property (ch1_timer_irq && en_sh[1] && !slv_sh[1]);
    c_slave: cover property (master_timer_irq && en_sh[2] && slv_sh[2]);
    c_irq: cover property (channel_timer_irq);
endmodule

bind tcoc_timer tcoc_timer_props i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .prescale_tick(prescale_tick),
    .timer_input_pin(timer_input_pin), .master_timer_irq(master_timer_irq),
    .ch1_timer_irq(ch1_timer_irq), .ch2_timer_irq(ch2_timer_irq),
    .channel_timer_irq(channel_timer_irq), .timer_out_pin(timer_out_pin));

// file: tb/test_timer_channel_output_control.sv
`timescale 1ns/1ns
module test_timer_channel_output_control;
    reg pclk;
    reg presetn;
    reg psel;
    reg penable;
    reg pwrite;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    reg [3:0] tick;
    reg tin;
    reg [2:0] irq_in;
    wire pready;
    wire pslverr;
    wire cirq;
    wire [31:0] prdata;
    wire [3:1] pin;
    wire [3:1] lit;
    integer err_total, compares, irqs, r, er, n, i, c, k, md, d, c0, sel;
    integer m [0:7];

    tcoc_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .prescale_tick(tick), .timer_input_pin(tin),
        .master_timer_irq(irq_in[0]), .ch1_timer_irq(irq_in[1]), .ch2_timer_irq(irq_in[2]),
        .channel_timer_irq(cirq), .timer_out_pin(pin));
    tcoc_led_model i_led (.drive_pin(pin), .led_lit(lit));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk)
        if (cirq === 1'b1)
            irqs = irqs + 1;

    task report_and_stop;
    begin
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task apb(input w, input [7:0] a, input [31:0] dat);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n = n + 1;
        end
        if (n == 20)
            err_total = err_total + 1;
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    // Register model follows each write except to the counter (8'h18) and control register (8'h1c)
    task wr(input [7:0] a, input [31:0] dat);
    begin
        apb(1'b1, a, dat);
        case (a)
            8'h00: m[0] = dat & 32'hdfcf;
            8'h0c: m[3] = (m[3] & m[4]) | (dat & 32'he & ~m[4]);
            8'h14: m[5] = dat & 32'hffff;
            8'h04, 8'h08, 8'h10: m[a >> 2] = dat & 32'he;
            default: ;
        endcase
    end
    endtask

    task rd(input [7:0] a);
    begin
        apb(1'b0, a, 32'h0);
        chk(r, m[a >> 2]);
        chk(er, 0);
    end
    endtask

    // Bits: 0 master, 1 and 2 own; own wins in slave mode
    task pulse(input [3:0] s);
    begin
        @(posedge pclk);
        irq_in <= s[2:0];
        @(posedge pclk);
        irq_in <= 3'h0;
        for (k = 1; k < 4; k = k + 1)
            if (m[4][k])
            begin
                if (!m[1][k] && s[k])
                    m[3] = m[3] ^ (1 << k);
                else if (m[1][k] && s[k])
                    m[3] = m[3] & ~(1 << k);
                else if (m[1][k] && s[0])
                    m[3] = m[3] | (1 << k);
            end
        @(posedge pclk);
    end
    endtask

    task ev(input p, input [3:0] t);
    begin
        @(posedge pclk);
        if (p)
            tin <= 1'b1;
        else
            tick <= t;
        @(posedge pclk);
        tick <= 4'h0;
        if (p)
        begin
            repeat (4) @(posedge pclk);
            tin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    end
    endtask

    initial
    begin
        #200000;
        err_total = err_total + 1;
        report_and_stop;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, tin} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        tick = 4'h0;
        irq_in = 3'h0;
        err_total = 0;
        compares = 0;
        irqs = 0;
        for (i = 0; i < 8; i = i + 1)
            m[i] = 0;
        r = $urandom(32'h2bf9);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (c = 0; c < 8; c = c + 1)
            rd(c * 4);
        apb(1'b0, 8'h20, 32'h0);
        chk(er, 1);
        chk(r, 0);
        for (i = 0; i < 24; i = i + 1)
        begin
            wr(8'h00, $urandom & 32'hf8ff);
            wr(8'h10, $urandom);
            wr(8'h08, $urandom);
            wr(8'h04, $urandom);
            wr(8'h0c, $urandom);
            apb(1'b1, 8'h24, $urandom);
            for (c = 0; c < 5; c = c + 1)
                rd(c * 4);
            pulse($urandom & 7);
            rd(8'h0c);
            chk(pin, (m[3] ^ (m[2] & m[4])) >> 1);
            chk(lit, (~(m[3] ^ (m[2] & m[4])) >> 1) & 7);
        end
        wr(8'h10, 32'h0);
        for (c = 0; c < 4; c = c + 1)
        begin
            md = (c == 1) ? 1 : (c == 2) ? 6 : 0;
            sel = (c == 1) ? 4 : (c == 2) ? 2 : 1 << c;
            d = (c == 3) ? 32'h0105 : 32'h0004;
            wr(8'h00, c << 14 | (c == 2) << 12 | (c == 3) << 11 | 32'h40 | md);
            wr(8'h14, d);
            c0 = irqs;
            wr(8'h1c, 32'h1);
            repeat (4) @(posedge pclk);
            chk(irqs - c0, md == 1);
            for (k = 0; k < 4; k = k + 1)
                ev(1'b0, (c == 2) ? 15 : 15 ^ sel);
            for (k = 0; k < (d & 255); k = k + 1)
                ev(c == 2, sel);
            chk(irqs - c0, md == 1);
            ev(c == 2, sel);
            repeat (3) @(posedge pclk);
            chk(irqs - c0, (md == 1) + 1);
            wr(8'h1c, 32'h2);
        end
        // Trigger sources, stop, one-count and capture
        c0 = irqs;
        wr(8'h00, 32'h0000);
        pulse(4'h1);
        ev(1'b1, 4'h0);
        rd(8'h1c);
        wr(8'h00, 32'h0400);
        wr(8'h14, 32'h1);
        pulse(4'h1);
        m[7] = 1;
        rd(8'h1c);
        wr(8'h1c, 32'h2);
        m[7] = 0;
        rd(8'h1c);
        wr(8'h00, 32'h0108);
        wr(8'h14, 32'h2);
        @(posedge pclk);
        tin <= 1'b1;
        repeat (5) @(posedge pclk);
        rd(8'h1c);
        @(posedge pclk);
        tin <= 1'b0;
        repeat (5) @(posedge pclk);
        m[7] = 1;
        rd(8'h1c);
        ev(1'b0, 4'h1);
        ev(1'b1, 4'h0);
        m[6] = 1;
        rd(8'h18);
        wr(8'h00, 32'h0109);
        ev(1'b1, 4'h0);
        m[6] = 2;
        rd(8'h18);
        for (k = 0; k < 3; k = k + 1)
            ev(1'b0, 4'h1);
        m[7] = 0;
        rd(8'h1c);
        chk(irqs - c0, 1);
        c0 = irqs;
        wr(8'h00, 32'h0205);
        wr(8'h1c, 32'h1);
        for (k = 0; k < 3; k = k + 1)
            ev(1'b0, 4'h1);
        @(posedge pclk);
        tin <= 1'b1;
        repeat (5) @(posedge pclk);
        m[5] = 3;
        rd(8'h14);
        for (k = 0; k < 2; k = k + 1)
            ev(1'b0, 4'h1);
        @(posedge pclk);
        tin <= 1'b0;
        repeat (5) @(posedge pclk);
        m[5] = 2;
        rd(8'h14);
        chk(irqs - c0, 3);
        wr(8'h1c, 32'h2);
        c0 = irqs;
        wr(8'h00, 32'h014c);
        ev(1'b1, 4'h0);
        for (k = 0; k < 2; k = k + 1)
            ev(1'b0, 4'h1);
        ev(1'b1, 4'h0);
        m[5] = 2;
        rd(8'h14);
        rd(8'h1c);
        chk(irqs - c0, 1);
        report_and_stop;
    end
endmodule
